// ==== core/csfm_pkg.sv ====
// Constants, register map and types of the clock switch and fail-safe monitor
package csfm_pkg;
	// ==========================================================
	// Register map (byte addresses, one 32-bit word each)
	localparam int CSFM_ADDR_W = 5;
	localparam logic [4:0] CSFM_OFF_REQUEST = 5'h00;
	localparam logic [4:0] CSFM_OFF_CURRENT = 5'h04;
	localparam logic [4:0] CSFM_OFF_SWCTRL = 5'h08;
	localparam logic [4:0] CSFM_OFF_FREQSEL = 5'h0C;
	localparam logic [4:0] CSFM_OFF_STATUS = 5'h10;

	// ==========================================================
	// Field layout
	localparam int CSFM_SRC_W = 3;
	localparam int CSFM_DIV_W = 4;
	localparam int CSFM_FRQ_W = 4;
	localparam int CSFM_SRC_LSB = 0;
	localparam int CSFM_DIV_LSB = 4;
	localparam int CSFM_FRQ_LSB = 0;
	localparam int CSFM_BIT_NSR = 3;
	localparam int CSFM_BIT_OSC_READY_STATUS = 4;
	localparam int CSFM_BIT_HOLD = 7;
	localparam int CSFM_BIT_SWIF = 0;
	localparam int CSFM_BIT_SWIE = 1;
	localparam int CSFM_BIT_HFR = 2;
	localparam int CSFM_BIT_MFR = 3;
	localparam int CSFM_BIT_FAIL = 4;
	localparam int CSFM_BIT_FSEN = 5;
	localparam int CSFM_BIT_REDUCED_CPU_RATE_EN = 6;

	// ==========================================================
	// Clock sources, also the index of each source's ready input
	localparam int CSFM_NUM_SRC = 6;
	typedef enum logic [2:0] {
		CSFM_SRC_EXT = 3'h0,
		CSFM_SRC_HF = 3'h1,
		CSFM_SRC_LF = 3'h2,
		CSFM_SRC_SEC = 3'h3,
		CSFM_SRC_EXT_PLL = 3'h4,
		CSFM_SRC_HF_PLL = 3'h5
	} csfm_src_t;

	// Switch sequencer, Gray coded along idle, wait, hold
	typedef enum logic [1:0] {
		CSFM_ST_IDLE = 2'b00,
		CSFM_ST_WAIT = 2'b01,
		CSFM_ST_HOLD = 2'b11
	} csfm_state_t;

	// ==========================================================
	// Reset values and divider figures
	localparam logic [2:0] CSFM_RST_SRC = 3'h1;
	localparam logic [3:0] CSFM_RST_DIV = 4'h0;
	localparam logic [3:0] CSFM_RST_FRQ = 4'h0;
	localparam int CSFM_MF_HI_KHZ = 500;
	localparam int CSFM_MF_LO_KHZ = 32;
	localparam int CSFM_SAMPLE_DIV = 64;
	localparam int CSFM_CNT_W = 16;
endpackage

// ==== core/csfm_top.sv ====
// Clock source switch sequencer, internal clock dividers and fail-safe monitor
// Notes on behaviour
// - Writing frequency select clears high and medium ready flags until oscillator is ready.
// - Medium clocks freeze at their level while a frequency change is pending.
// - Internal clocks run, except the medium clocks while a frequency change is pending; ready flags only mean the frequency is accurate.
// - High oscillator yields 500 kHz and 32 kHz clocks; low oscillator gives 31 kHz.
// - Six system clock choices, including two PLL paths.
// - After a request the present clock runs until the requested source is ready.
// - Source already running or divider-only change counts as ready at once.
// - Waiting for a new source continues regardless of sleep.
// - Ready sets new-source-ready and switch flag; interrupt only if enable is one.
// - Oscillator ready status bit can be polled instead of the interrupt.
// - Hold clear: clock changes when new-source-ready sets.
// - Hold set: keep old clock even after the new source is ready.
// - Under reduced CPU rate the switch still happens on the next clock.
// - Divider-only change runs the same request, ready, switch sequence.
// - Switch flag is cleared only by software, never by hardware.
// - Ready status reads zero while request and current differ; mismatch starts a switch.
// - Fail-safe monitor, when enabled, watches every external source, secondary included.
// - Sample clock is the low oscillator divided by 64.
// - Latch set on external falling edge, cleared on sample rising edge.
// - Failure when a whole sample half period passes without external falling edge.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module csfm_top
	import csfm_pkg::*;
#(
	parameter int HF_NOMINAL_KHZ = 32000,
	parameter int HF_RESTART_EDGES = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Avalon-MM slave
	input wire logic [CSFM_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Oscillator pins and readiness
	input wire logic i_external_osc,
	input wire logic i_hf_internal_osc,
	input wire logic i_lf_internal_osc,
	input wire logic i_secondary_osc,
	input wire logic i_hf_osc_stable,
	input wire logic [CSFM_NUM_SRC-1:0] i_src_ready,
	// Clock selection and derived clocks
	output logic [CSFM_SRC_W-1:0] o_sys_clk_sel,
	output logic [CSFM_DIV_W-1:0] o_sys_div,
	output logic [CSFM_FRQ_W-1:0] o_internal_freq_select,
	output logic o_mf_clk_500k,
	output logic o_mf_clk_32k,
	output logic o_lf_clk_31k,
	// Events
	output logic o_switch_irq,
	output logic o_clock_failed
);
	// ==========================================================
	// Derived counts
	localparam logic [CSFM_CNT_W-1:0] MF_HI_HALF = CSFM_CNT_W'(HF_NOMINAL_KHZ / (2 * CSFM_MF_HI_KHZ) - 1);
	localparam logic [CSFM_CNT_W-1:0] MF_LO_HALF = CSFM_CNT_W'(HF_NOMINAL_KHZ / (2 * CSFM_MF_LO_KHZ) - 1);
	localparam logic [CSFM_CNT_W-1:0] SAMPLE_HALF = CSFM_CNT_W'(CSFM_SAMPLE_DIV / 2 - 1);
	localparam logic [CSFM_CNT_W-1:0] RESTART_CNT = CSFM_CNT_W'(HF_RESTART_EDGES);
	localparam int NSYNC = 5 + CSFM_NUM_SRC;

	// ==========================================================
	// Reset release
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Pin synchronisers: three stages, change accepted when stages two and three agree
	logic [NSYNC-1:0] pin_in;
	logic [NSYNC-1:0] s1_ff;
	logic [NSYNC-1:0] s2_ff;
	logic [NSYNC-1:0] s3_ff;
	logic [NSYNC-1:0] filt_ff;
	logic [NSYNC-1:0] prev_ff;
	assign pin_in = {i_src_ready, i_hf_osc_stable, i_secondary_osc, i_lf_internal_osc, i_hf_internal_osc,
		i_external_osc};
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_ff[g] <= 1'b0;
					s2_ff[g] <= 1'b0;
					s3_ff[g] <= 1'b0;
					filt_ff[g] <= 1'b0;
					prev_ff[g] <= 1'b0;
				end else begin
					s1_ff[g] <= pin_in[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					filt_ff[g] <= (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : filt_ff[g];
					prev_ff[g] <= filt_ff[g];
				end
			end
		end
	endgenerate

	// Named views of the filtered pins
	logic ext_fall;
	logic sec_fall;
	logic hf_rise;
	logic lf_rise;
	logic hf_stable;
	logic [CSFM_NUM_SRC-1:0] src_ready;
	assign ext_fall = prev_ff[0] & ~filt_ff[0];
	assign hf_rise = filt_ff[1] & ~prev_ff[1];
	assign lf_rise = filt_ff[2] & ~prev_ff[2];
	assign sec_fall = prev_ff[3] & ~filt_ff[3];
	assign hf_stable = filt_ff[4];
	assign src_ready = filt_ff[NSYNC-1:5];

	// ==========================================================
	// Avalon slave handshake: waitrequest drops for one cycle per request
	logic waitreq_ff;
	logic wr_en;
	logic rd_take;
	assign wr_en = i_avs_write & ~waitreq_ff & i_avs_byteenable[0];
	assign rd_take = i_avs_read & waitreq_ff;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitreq_ff <= 1'b1;
		end else begin
			waitreq_ff <= ~((i_avs_read | i_avs_write) & waitreq_ff);
		end
	end
	assign o_avs_waitrequest = waitreq_ff;

	// Write strobes per register
	logic wr_req;
	logic wr_ctrl;
	logic wr_frq;
	logic wr_stat;
	assign wr_req = wr_en && (i_avs_address == CSFM_OFF_REQUEST);
	assign wr_ctrl = wr_en && (i_avs_address == CSFM_OFF_SWCTRL);
	assign wr_frq = wr_en && (i_avs_address == CSFM_OFF_FREQSEL);
	assign wr_stat = wr_en && (i_avs_address == CSFM_OFF_STATUS);

	// ==========================================================
	// Software registers
	logic [CSFM_SRC_W-1:0] req_src_ff;
	logic [CSFM_DIV_W-1:0] req_div_ff;
	logic hold_ff;
	logic irq_en_ff;
	logic fs_en_ff;
	logic reduced_cpu_rate_ff;
	logic fail_evt;
	logic [CSFM_SRC_W-1:0] wr_src;
	assign wr_src = i_avs_writedata[CSFM_SRC_LSB +: CSFM_SRC_W];

	// Request register; codes beyond the six sources are ignored
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_src_ff <= CSFM_RST_SRC;
			req_div_ff <= CSFM_RST_DIV;
		end else if (fail_evt) begin
			req_src_ff <= CSFM_SRC_HF;
		end else if (wr_req && (wr_src < CSFM_SRC_W'(CSFM_NUM_SRC))) begin
			req_src_ff <= wr_src;
			req_div_ff <= i_avs_writedata[CSFM_DIV_LSB +: CSFM_DIV_W];
		end
	end

	// Control bits
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			fs_en_ff <= 1'b0;
			reduced_cpu_rate_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				hold_ff <= i_avs_writedata[CSFM_BIT_HOLD];
			end
			if (wr_stat) begin
				irq_en_ff <= i_avs_writedata[CSFM_BIT_SWIE];
				fs_en_ff <= i_avs_writedata[CSFM_BIT_FSEN];
				reduced_cpu_rate_ff <= i_avs_writedata[CSFM_BIT_REDUCED_CPU_RATE_EN];
			end
		end
	end

	// ==========================================================
	// Internal frequency select and restart tracking
	logic [CSFM_FRQ_W-1:0] frq_ff;
	logic frq_pend_ff;
	logic [CSFM_CNT_W-1:0] restart_cnt_ff;
	logic hf_rdy_ff;
	logic mf_rdy_ff;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			frq_ff <= CSFM_RST_FRQ;
			frq_pend_ff <= 1'b0;
			restart_cnt_ff <= '0;
		end else if (wr_frq) begin
			frq_ff <= i_avs_writedata[CSFM_FRQ_LSB +: CSFM_FRQ_W];
			frq_pend_ff <= 1'b1;
			restart_cnt_ff <= '0;
		end else if (frq_pend_ff) begin
			if (hf_stable && (restart_cnt_ff >= RESTART_CNT)) begin
				frq_pend_ff <= 1'b0;
			end else if (hf_rise && (restart_cnt_ff < RESTART_CNT)) begin
				restart_cnt_ff <= restart_cnt_ff + 1'b1;
			end
		end
	end
	assign o_internal_freq_select = frq_ff;

	// Ready flags mean accuracy only; they never gate the clocks
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			hf_rdy_ff <= 1'b0;
			mf_rdy_ff <= 1'b0;
		end else begin
			hf_rdy_ff <= hf_stable & ~frq_pend_ff & ~wr_frq;
			mf_rdy_ff <= hf_stable & ~frq_pend_ff & ~wr_frq;
		end
	end

	// ==========================================================
	// Medium and low frequency clocks
	logic [CSFM_CNT_W-1:0] mf_hi_cnt_ff;
	logic [CSFM_CNT_W-1:0] mf_lo_cnt_ff;
	logic mf_hi_ff;
	logic mf_lo_ff;
	logic lf_out_ff;
	// Counting stops during a pending change, so each output holds its level
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			mf_hi_cnt_ff <= '0;
			mf_lo_cnt_ff <= '0;
			mf_hi_ff <= 1'b0;
			mf_lo_ff <= 1'b0;
		end else if (hf_rise && !frq_pend_ff) begin
			if (mf_hi_cnt_ff >= MF_HI_HALF) begin
				mf_hi_cnt_ff <= '0;
				mf_hi_ff <= ~mf_hi_ff;
			end else begin
				mf_hi_cnt_ff <= mf_hi_cnt_ff + 1'b1;
			end
			if (mf_lo_cnt_ff >= MF_LO_HALF) begin
				mf_lo_cnt_ff <= '0;
				mf_lo_ff <= ~mf_lo_ff;
			end else begin
				mf_lo_cnt_ff <= mf_lo_cnt_ff + 1'b1;
			end
		end
	end

	// Low oscillator passed straight on as the 31 kHz clock
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			lf_out_ff <= 1'b0;
		end else begin
			lf_out_ff <= filt_ff[2];
		end
	end
	assign o_mf_clk_500k = mf_hi_ff;
	assign o_mf_clk_32k = mf_lo_ff;
	assign o_lf_clk_31k = lf_out_ff;

	// ==========================================================
	// Fail-safe sample clock and edge latch
	logic [CSFM_CNT_W-1:0] smp_cnt_ff;
	logic smp_ff;
	logic smp_rise;
	logic smp_fall;
	logic edge_latch_ff;
	logic fail_ff;
	logic mon_fall;
	logic cur_external;
	logic [CSFM_SRC_W-1:0] cur_src_ff;
	assign smp_rise = lf_rise && (smp_cnt_ff >= SAMPLE_HALF) && !smp_ff;
	assign smp_fall = lf_rise && (smp_cnt_ff >= SAMPLE_HALF) && smp_ff;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			smp_cnt_ff <= '0;
			smp_ff <= 1'b0;
		end else if (lf_rise) begin
			if (smp_cnt_ff >= SAMPLE_HALF) begin
				smp_cnt_ff <= '0;
				smp_ff <= ~smp_ff;
			end else begin
				smp_cnt_ff <= smp_cnt_ff + 1'b1;
			end
		end
	end

	// Secondary source is watched on its own pin, external and external PLL on the external pin
	assign cur_external = (cur_src_ff == CSFM_SRC_EXT) || (cur_src_ff == CSFM_SRC_EXT_PLL)
		|| (cur_src_ff == CSFM_SRC_SEC);
	assign mon_fall = (cur_src_ff == CSFM_SRC_SEC) ? sec_fall : ext_fall;

	// Set wins so an edge coinciding with the sample edge is kept
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_latch_ff <= 1'b0;
		end else if (mon_fall) begin
			edge_latch_ff <= 1'b1;
		end else if (smp_rise) begin
			edge_latch_ff <= 1'b0;
		end
	end
	assign fail_evt = fs_en_ff && cur_external && smp_fall && !edge_latch_ff && !mon_fall;

	// Failure flag, write one to clear, new failure wins
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			fail_ff <= 1'b0;
		end else if (fail_evt) begin
			fail_ff <= 1'b1;
		end else if (wr_stat && i_avs_writedata[CSFM_BIT_FAIL]) begin
			fail_ff <= 1'b0;
		end
	end
	assign o_clock_failed = fail_ff;

	// ==========================================================
	// Switch sequencer
	csfm_state_t state_ff;
	logic [CSFM_DIV_W-1:0] cur_div_ff;
	logic [CSFM_SRC_W-1:0] tgt_src_ff;
	logic [CSFM_DIV_W-1:0] tgt_div_ff;
	logic nsr_ff;
	logic req_match;
	logic tgt_changed;
	logic tgt_ready;
	logic ready_evt;
	assign req_match = (req_src_ff == cur_src_ff) && (req_div_ff == cur_div_ff);
	assign tgt_changed = (req_src_ff != tgt_src_ff) || (req_div_ff != tgt_div_ff);
	assign tgt_ready = (tgt_src_ff == cur_src_ff) || src_ready[tgt_src_ff];
	assign ready_evt = (state_ff == CSFM_ST_WAIT) && !req_match && !tgt_changed && tgt_ready && !fail_evt;

	// No sleep or reduced-rate gating: the wait and the switch run on every edge
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CSFM_ST_IDLE;
			cur_src_ff <= CSFM_RST_SRC;
			cur_div_ff <= CSFM_RST_DIV;
			tgt_src_ff <= CSFM_RST_SRC;
			tgt_div_ff <= CSFM_RST_DIV;
			nsr_ff <= 1'b0;
		end else if (fail_evt) begin
			cur_src_ff <= CSFM_SRC_HF;
			tgt_src_ff <= CSFM_SRC_HF;
			state_ff <= CSFM_ST_IDLE;
			nsr_ff <= 1'b0;
		end else begin
			case (state_ff)
				CSFM_ST_IDLE: begin
					if (!req_match) begin
						tgt_src_ff <= req_src_ff;
						tgt_div_ff <= req_div_ff;
						nsr_ff <= 1'b0;
						state_ff <= CSFM_ST_WAIT;
					end
				end
				CSFM_ST_WAIT: begin
					if (req_match) begin
						state_ff <= CSFM_ST_IDLE;
					end else if (tgt_changed) begin
						tgt_src_ff <= req_src_ff;
						tgt_div_ff <= req_div_ff;
					end else if (tgt_ready) begin
						nsr_ff <= 1'b1;
						if (hold_ff) begin
							state_ff <= CSFM_ST_HOLD;
						end else begin
							cur_src_ff <= tgt_src_ff;
							cur_div_ff <= tgt_div_ff;
							state_ff <= CSFM_ST_IDLE;
						end
					end
				end
				CSFM_ST_HOLD: begin
					if (req_match) begin
						nsr_ff <= 1'b0;
						state_ff <= CSFM_ST_IDLE;
					end else if (tgt_changed) begin
						tgt_src_ff <= req_src_ff;
						tgt_div_ff <= req_div_ff;
						nsr_ff <= 1'b0;
						state_ff <= CSFM_ST_WAIT;
					end else if (!hold_ff) begin
						cur_src_ff <= tgt_src_ff;
						cur_div_ff <= tgt_div_ff;
						state_ff <= CSFM_ST_IDLE;
					end
				end
				default: begin
					state_ff <= CSFM_ST_IDLE;
				end
			endcase
		end
	end
	assign o_sys_clk_sel = cur_src_ff;
	assign o_sys_div = cur_div_ff;

	// ==========================================================
	// Switch flag and interrupt; hardware only sets, software clears
	logic swif_ff;
	logic irq_ff;
	logic osc_ready_status_ff;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			swif_ff <= 1'b0;
		end else if (ready_evt) begin
			swif_ff <= 1'b1;
		end else if (wr_stat && i_avs_writedata[CSFM_BIT_SWIF]) begin
			swif_ff <= 1'b0;
		end
	end

	// Interrupt level and polled ready status
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
			osc_ready_status_ff <= 1'b0;
		end else begin
			irq_ff <= (swif_ff | ready_evt) & irq_en_ff;
			osc_ready_status_ff <= req_match && (state_ff == CSFM_ST_IDLE);
		end
	end
	assign o_switch_irq = irq_ff;

	// ==========================================================
	// Read data, captured when the request is first seen
	logic [31:0] rd_mux;
	logic [31:0] rd_ff;
	always_comb begin
		rd_mux = '0;
		if (i_avs_address == CSFM_OFF_REQUEST) begin
			rd_mux[CSFM_SRC_LSB +: CSFM_SRC_W] = req_src_ff;
			rd_mux[CSFM_DIV_LSB +: CSFM_DIV_W] = req_div_ff;
		end else if (i_avs_address == CSFM_OFF_CURRENT) begin
			rd_mux[CSFM_SRC_LSB +: CSFM_SRC_W] = cur_src_ff;
			rd_mux[CSFM_DIV_LSB +: CSFM_DIV_W] = cur_div_ff;
		end else if (i_avs_address == CSFM_OFF_SWCTRL) begin
			rd_mux[CSFM_BIT_NSR] = nsr_ff;
			rd_mux[CSFM_BIT_OSC_READY_STATUS] = osc_ready_status_ff;
			rd_mux[CSFM_BIT_HOLD] = hold_ff;
		end else if (i_avs_address == CSFM_OFF_FREQSEL) begin
			rd_mux[CSFM_FRQ_LSB +: CSFM_FRQ_W] = frq_ff;
		end else if (i_avs_address == CSFM_OFF_STATUS) begin
			rd_mux[CSFM_BIT_SWIF] = swif_ff;
			rd_mux[CSFM_BIT_SWIE] = irq_en_ff;
			rd_mux[CSFM_BIT_HFR] = hf_rdy_ff;
			rd_mux[CSFM_BIT_MFR] = mf_rdy_ff;
			rd_mux[CSFM_BIT_FAIL] = fail_ff;
			rd_mux[CSFM_BIT_FSEN] = fs_en_ff;
			rd_mux[CSFM_BIT_REDUCED_CPU_RATE_EN] = reduced_cpu_rate_ff;
		end
	end

	// Held until the next read so the data stand at the sampling edge
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ff <= '0;
		end else if (rd_take) begin
			rd_ff <= rd_mux;
		end
	end
	assign o_avs_readdata = rd_ff;
endmodule

// ==== bench/csfm_monitor.sv ====
// Port-level assertions for the clock switch and fail-safe block
`timescale 1ns/100ps
module csfm_monitor
	import csfm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register bus
	input wire logic [CSFM_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	// Selection and events
	input wire logic [CSFM_SRC_W-1:0] o_sys_clk_sel,
	input wire logic [CSFM_FRQ_W-1:0] o_internal_freq_select,
	input wire logic o_switch_irq,
	input wire logic o_clock_failed
);
	// ==========================================================
	// One domain, so clocking and reset are shared
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Write accepted at this edge
	logic wr_done;
	assign wr_done = i_avs_write && !o_avs_waitrequest;

	// ==========================================================
	// Bus handshake
	property p_bus_answer; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("request not answered");
	property p_bus_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_bus_one: assert property (p_bus_one) else $error("waitrequest low too long");
	property p_bus_idle; !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_bus_idle: assert property (p_bus_idle) else $error("answer without a request");

	// ==========================================================
	// Switch sequencing
	property p_sel_legal; o_sys_clk_sel <= 3'h5; endproperty
	a_sel_legal: assert property (p_sel_legal) else $error("illegal source code");
	property p_req_keep; wr_done && i_avs_address == CSFM_OFF_REQUEST |=> $stable(o_sys_clk_sel); endproperty
	a_req_keep: assert property (p_req_keep) else $error("source changed on request write");
	property p_irq_hold; o_switch_irq && !wr_done && !$past(wr_done) |=> o_switch_irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
	property p_frq_cause; $changed(o_internal_freq_select) |-> $past(wr_done) && $past(i_avs_address) == CSFM_OFF_FREQSEL; endproperty
	a_frq_cause: assert property (p_frq_cause) else $error("frequency select changed alone");

	// ==========================================================
	// Fail-safe
	property p_fail_hf; $rose(o_clock_failed) |-> o_sys_clk_sel == CSFM_SRC_HF; endproperty
	a_fail_hf: assert property (p_fail_hf) else $error("no fall back to internal source");
	property p_fail_ext; $rose(o_clock_failed) |-> $past(o_sys_clk_sel) inside {3'h0, 3'h3, 3'h4}; endproperty
	a_fail_ext: assert property (p_fail_ext) else $error("failure on an internal source");
	property p_fail_hold; o_clock_failed && !wr_done |=> o_clock_failed; endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("failure flag dropped alone");

	// Main scenarios reached
	c_fail: cover property ($rose(o_clock_failed));
	c_irq: cover property ($rose(o_switch_irq));
	c_switch: cover property ($changed(o_sys_clk_sel));
endmodule

// ==== bench/csfm_osc_model.sv ====
// Behavioural oscillators standing at the far side of the clock switch block
`timescale 1ns/100ps
module csfm_osc_model (
	// Run control
	input wire logic i_ext_run,
	// Oscillator outputs
	output logic o_external_osc,
	output logic o_hf_internal_osc,
	output logic o_lf_internal_osc,
	output logic o_secondary_osc,
	output logic o_hf_osc_stable
);
	// ==========================================================
	// Start levels; edges sit off the bench clock rising edges
	initial begin
		o_external_osc = 1'b0;
		o_hf_internal_osc = 1'b0;
		o_lf_internal_osc = 1'b0;
		o_secondary_osc = 1'b0;
		o_hf_osc_stable = 1'b1;
	end

	// Internal and secondary oscillators never stop
	always #40 o_hf_internal_osc = ~o_hf_internal_osc;
	always #60 o_lf_internal_osc = ~o_lf_internal_osc;
	always #70 o_secondary_osc = ~o_secondary_osc;

	// External source; a dead crystal freezes at its last level
	always begin
		#50;
		if (i_ext_run) begin
			o_external_osc = ~o_external_osc;
		end
	end
endmodule

// ==== bench/csfm_top_bench.sv ====
// Self-checking bench for the clock switch and fail-safe block
`timescale 1ns/100ps
module csfm_top_bench
	import csfm_pkg::*;
;
	// ==========================================================
	// Signals
	logic i_clk = 1'b0;
	logic i_reset_n;
	logic [4:0] i_avs_address;
	logic i_avs_read;
	logic i_avs_write;
	logic [31:0] i_avs_writedata;
	logic [3:0] i_avs_byteenable;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic ext_osc, hf_osc, lf_osc, sec_osc, hf_stable, ext_run;
	logic [5:0] i_src_ready;
	logic [2:0] o_sys_clk_sel;
	logic [3:0] o_sys_div, o_internal_freq_select;
	logic mf_500k, mf_32k, lf_31k, o_switch_irq, o_clock_failed;
	logic [31:0] rd;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;

	// Design and oscillators
	csfm_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_external_osc(ext_osc), .i_hf_internal_osc(hf_osc),
		.i_lf_internal_osc(lf_osc), .i_secondary_osc(sec_osc), .i_hf_osc_stable(hf_stable),
		.i_src_ready(i_src_ready), .o_sys_clk_sel(o_sys_clk_sel), .o_sys_div(o_sys_div),
		.o_internal_freq_select(o_internal_freq_select), .o_mf_clk_500k(mf_500k), .o_mf_clk_32k(mf_32k),
		.o_lf_clk_31k(lf_31k), .o_switch_irq(o_switch_irq), .o_clock_failed(o_clock_failed));
	csfm_osc_model osc (.i_ext_run(ext_run), .o_external_osc(ext_osc), .o_hf_internal_osc(hf_osc),
		.o_lf_internal_osc(lf_osc), .o_secondary_osc(sec_osc), .o_hf_osc_stable(hf_stable));

	// ==========================================================
	// Clock and hang guard; longest wait is the fail-safe detection
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= 1'b1;
		@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
		i_avs_write <= 1'b0;
	endtask
	task automatic bus_read(input logic [4:0] a);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_read <= 1'b1;
		@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
		rd = o_avs_readdata;
		i_avs_read <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
		bus_read(a);
		check(rd & mask, exp);
	endtask
	// Poll until all mask bits are set, bounded
	task automatic poll(input logic [4:0] a, input logic [31:0] mask);
		int n;
		n = 0;
		bus_read(a);
		while ((rd & mask) !== mask && n < 500) begin
			bus_read(a);
			n++;
		end
		check(rd & mask, mask);
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		i_reset_n = 1'b0;
		i_avs_address = 5'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0000_0000;
		i_avs_byteenable = 4'hF;
		i_src_ready = 6'h02;
		ext_run = 1'b1;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		// Reset state, unmapped hole, 500 kHz period
		rdc(CSFM_OFF_REQUEST, 32'hFFFF_FFFF, 32'h0000_0001);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0001);
		rdc(CSFM_OFF_STATUS, 32'h0000_0013, 32'h0000_0000);
		rdc(5'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		@(mf_500k) rd = 32'(mf_500k);
		repeat (250) @(posedge i_clk);
		check(32'(mf_500k), rd);
		repeat (10) @(posedge i_clk);
		check(32'(mf_500k), rd ^ 32'h0000_0001);
		// Switch to external; old clock kept until it is ready
		bus_write(CSFM_OFF_REQUEST, 32'h0000_0000);
		repeat (10) @(posedge i_clk);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0001);
		rdc(CSFM_OFF_SWCTRL, 32'h0000_0098, 32'h0000_0000);
		i_src_ready <= 6'h03;
		poll(CSFM_OFF_SWCTRL, 32'h0000_0018);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0000);
		rdc(CSFM_OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
		check(32'(o_switch_irq), 32'h0000_0000);
		// Enable, then clear the flag; reduced rate left on for the rest
		bus_write(CSFM_OFF_STATUS, 32'h0000_0042);
		repeat (2) @(posedge i_clk);
		check(32'(o_switch_irq), 32'h0000_0001);
		bus_write(CSFM_OFF_STATUS, 32'h0000_0043);
		repeat (2) @(posedge i_clk);
		check(32'(o_switch_irq), 32'h0000_0000);
		// Divider-only change under hold
		bus_write(CSFM_OFF_SWCTRL, 32'h0000_0080);
		bus_write(CSFM_OFF_REQUEST, 32'h0000_0020);
		poll(CSFM_OFF_SWCTRL, 32'h0000_0008);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0000);
		check(32'(o_switch_irq), 32'h0000_0001);
		bus_write(CSFM_OFF_SWCTRL, 32'h0000_0000);
		poll(CSFM_OFF_SWCTRL, 32'h0000_0010);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0020);
		check(32'(o_sys_div), 32'h0000_0002);
		// Held switch to low oscillator, then abandoned by writing current back
		bus_write(CSFM_OFF_SWCTRL, 32'h0000_0080);
		i_src_ready <= 6'h07;
		bus_write(CSFM_OFF_REQUEST, 32'h0000_0022);
		poll(CSFM_OFF_SWCTRL, 32'h0000_0008);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0020);
		bus_write(CSFM_OFF_REQUEST, 32'h0000_0020);
		poll(CSFM_OFF_SWCTRL, 32'h0000_0010);
		rdc(CSFM_OFF_SWCTRL, 32'h0000_0098, 32'h0000_0090);
		bus_write(CSFM_OFF_SWCTRL, 32'h0000_0000);
		// Illegal source code is refused whole
		bus_write(CSFM_OFF_REQUEST, 32'h0000_0056);
		rdc(CSFM_OFF_REQUEST, 32'hFFFF_FFFF, 32'h0000_0020);
		// Frequency select drops both ready flags until restart
		bus_write(CSFM_OFF_FREQSEL, 32'h0000_0005);
		rdc(CSFM_OFF_STATUS, 32'h0000_000C, 32'h0000_0000);
		poll(CSFM_OFF_STATUS, 32'h0000_000C);
		check(32'(o_internal_freq_select), 32'h0000_0005);
		// Fail-safe on a dead external source
		bus_write(CSFM_OFF_STATUS, 32'h0000_0062);
		ext_run <= 1'b0;
		poll(CSFM_OFF_STATUS, 32'h0000_0010);
		rdc(CSFM_OFF_CURRENT, 32'hFFFF_FFFF, 32'h0000_0021);
		check(32'(o_clock_failed), 32'h0000_0001);
		bus_write(CSFM_OFF_STATUS, 32'h0000_0072);
		rdc(CSFM_OFF_STATUS, 32'h0000_0010, 32'h0000_0000);
		report_and_stop();
	end
endmodule

// Checker attached to the design top
bind csfm_top csfm_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
	.o_sys_clk_sel(o_sys_clk_sel), .o_internal_freq_select(o_internal_freq_select),
	.o_switch_irq(o_switch_irq), .o_clock_failed(o_clock_failed));
